// ==== src/pxs_pkg.sv ====
// shared constants and types for the proximity sensor control core
package pxs_pkg;

  // bus address and command byte layout
  localparam logic [6:0] SLAVE_ADDR     = 7'h39;
  localparam int         CMD_FLAG_BIT   = 7;
  localparam logic [1:0] CT_REPEAT      = 2'h0;
  localparam logic [1:0] CT_AUTO_INC    = 2'h1;
  localparam logic [1:0] CT_SPECIAL     = 2'h3;
  localparam logic [4:0] SF_NOP         = 5'h00;
  localparam logic [4:0] SF_PIRQ_CLR_A  = 5'h05;
  localparam logic [4:0] SF_PIRQ_CLR_B  = 5'h07;

  // register offsets
  localparam logic [4:0] REG_ENABLE     = 5'h00;
  localparam logic [4:0] REG_INT_TIME   = 5'h02;
  localparam logic [4:0] REG_WAIT_TIME  = 5'h03;
  localparam logic [4:0] REG_LOW_TH_L   = 5'h08;
  localparam logic [4:0] REG_LOW_TH_H   = 5'h09;
  localparam logic [4:0] REG_HIGH_TH_L  = 5'h0a;
  localparam logic [4:0] REG_HIGH_TH_H  = 5'h0b;
  localparam logic [4:0] REG_PERSIST    = 5'h0c;
  localparam logic [4:0] REG_CONFIG     = 5'h0d;
  localparam logic [4:0] REG_PULSES     = 5'h0e;
  localparam logic [4:0] REG_CONTROL    = 5'h0f;
  localparam logic [4:0] REG_REVISION   = 5'h11;
  localparam logic [4:0] REG_STATUS     = 5'h13;
  localparam logic [4:0] REG_RESULT_L   = 5'h18;
  localparam logic [4:0] REG_RESULT_H   = 5'h19;

  // field positions
  localparam int ENA_POWER_ON_BIT = 0;
  localparam int ENA_PROX_BIT     = 2;
  localparam int ENA_WAIT_BIT     = 3;
  localparam int ENA_PIRQ_BIT     = 5;
  localparam int CFG_LONG_WAIT    = 1;
  localparam int PERS_PROX_LSB    = 4;
  localparam int STAT_VALID_BIT   = 0;
  localparam int STAT_PIRQ_BIT    = 5;

  // values after reset
  localparam logic [7:0] INT_TIME_RST  = 8'hff;
  localparam logic [7:0] WAIT_TIME_RST = 8'hff;

  // timing
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned PULSE_TIME_NS   = 16000;
  localparam int unsigned PULSE_CYCLES    = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STEP_TIME_NS    = 2720000;
  localparam int unsigned STEP_CYCLES_DEF = STEP_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned LONG_WAIT_MULT  = 12;
  localparam int unsigned STEPS_FULL      = 256;

  // serial engine states, gray along the byte path
  typedef enum logic [2:0] {
    BUS_IDLE     = 3'h0,
    BUS_ADDR     = 3'h1,
    BUS_ADDR_ACK = 3'h3,
    BUS_WR_BYTE  = 3'h2,
    BUS_WR_ACK   = 3'h6,
    BUS_RD_BYTE  = 3'h7,
    BUS_RD_ACK   = 3'h5,
    BUS_RD_NEXT  = 3'h4
  } pxs_bus_t;

  // measurement states, gray around the loop
  typedef enum logic [1:0] {
    MS_SLEEP = 2'h0,
    MS_ACCUM = 2'h1,
    MS_ADC   = 2'h3,
    MS_WAIT  = 2'h2
  } pxs_meas_t;

endpackage

// ==== src/pxs_sync.sv ====
// two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
module pxs_sync #(
  parameter int         W   = 1,
  parameter logic [0:0] RST = 1'b1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  input  wire logic         ce_i,
  // data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_reg;

  // first stage feeds only the second
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta_reg <= {W{RST}};
      q_o      <= {W{RST}};
    end
    else if (ce_i)
    begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end

endmodule

// ==== src/pxs_core.sv ====
// proximity sensor control core: serial slave, register file, measurement loop, threshold irq
//
// Contract
// - proximity interrupt is raised only while its enable bit is set
// - low and high thresholds are 16 bits, each written as two byte registers
// - threshold event when result is above high or below low threshold
// - interrupt only after event persists the programmed number of conversions
// - loop starts in sleep and leaves only once power-on is written one
// - with proximity enabled, accumulate comes first, then the conversion
// - the loop moves on at once when the conversion ends
// - with wait enabled, a wait state follows the proximity states
// - long-wait bit stretches each wait step twelve times
// - serial slave answers only at one fixed seven-bit address
// - combined read: command write, repeated start, then device returns bytes
// - read without command uses the register address held from before
// - first byte with top bit clear is data stored at held address
// - command byte is a control command or carries a five-bit address
// - control commands 05 and 07 in the command byte clear a pending interrupt; other control commands do not
// - word read uses auto-increment, low byte first then high byte
// - integration setting all ones gives the shortest period, one step
// - wait setting all ones gives the shortest wait, one step
// - type field: 00 repeat, 01 auto-increment, 11 special, 10 reserved
// - special clear code clears pending proximity interrupt, then self-clears
// - power-on cleared: finish running conversion, then sleep
`timescale 1ns/100ps
module pxs_core
  import pxs_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = STEP_CYCLES_DEF,
  parameter logic [7:0]  REV_ID      = 8'h5a  // arbitrary value
) (
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        ce_i,
  // serial bus pins
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n_o,
  // analog front end
  input  wire logic [15:0] adc_value_i,
  output logic             led_on_o,
  output logic             adc_busy_o,
  output logic [7:0]       led_pulse_count_o,
  output logic [1:0]       led_drive_level_o,
  output logic [1:0]       photodiode_select_o,
  output logic [1:0]       prox_gain_o,
  // interrupt pin
  output logic             irq_n_o
);

  typedef struct packed {
    pxs_bus_t   bus;
    logic [2:0] bitn;
    logic [7:0] shreg;
    logic       rnw;
    logic       first;
    logic [4:0] addr;
    logic [1:0] ctype;
    logic       sda_oe_n;
    logic       scl_d;
    logic       sda_d;
    logic [7:0] enable;
    logic [7:0] int_time;
    logic [7:0] wait_time;
    logic [7:0] config_r;
    logic [7:0] persist;
    logic [7:0] pulses;
    logic [7:0] control;
    logic [15:0] low_th;
    logic [15:0] high_th;
    logic [15:0] result;
    logic       valid;
    logic       pirq;
    logic [3:0] pcnt;
    pxs_meas_t  ms;
    logic [31:0] tmr;
    logic       led_on;
    logic       adc_busy;
    logic       irq_n;
  } pxs_state_t;

  pxs_state_t state_reg;
  pxs_state_t state_next;
  logic       scl_s;
  logic       sda_s;

  // pins arrive from another clock domain
  pxs_sync #(
    .W   (2),
    .RST (1'b1)
  ) u_sync (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .ce_i     (ce_i),
    .d_i      ({scl_i, sda_i}),
    .q_o      ({scl_s, sda_s})
  );

  // register read map; unmapped offsets read zero
  function automatic logic [7:0] reg_read(pxs_state_t s, logic [4:0] a);
    logic [7:0] d;
    d = 8'h00;
    case (a)
      REG_ENABLE:    d = s.enable;
      REG_INT_TIME:  d = s.int_time;
      REG_WAIT_TIME: d = s.wait_time;
      REG_LOW_TH_L:  d = s.low_th[7:0];
      REG_LOW_TH_H:  d = s.low_th[15:8];
      REG_HIGH_TH_L: d = s.high_th[7:0];
      REG_HIGH_TH_H: d = s.high_th[15:8];
      REG_PERSIST:   d = s.persist;
      REG_CONFIG:    d = s.config_r;
      REG_PULSES:    d = s.pulses;
      REG_CONTROL:   d = s.control;
      REG_REVISION:  d = REV_ID;
      REG_STATUS:
      begin
        d[STAT_VALID_BIT] = s.valid;
        d[STAT_PIRQ_BIT]  = s.pirq;
      end
      REG_RESULT_L:  d = s.result[7:0];
      REG_RESULT_H:  d = s.result[15:8];
      default:       d = 8'h00;
    endcase
    return d;
  endfunction

  // register write map; read-only and unmapped offsets ignore writes
  function automatic pxs_state_t reg_write(pxs_state_t s, logic [4:0] a, logic [7:0] d);
    pxs_state_t t;
    t = s;
    case (a)
      REG_ENABLE:    t.enable = d;
      REG_INT_TIME:  t.int_time = d;
      REG_WAIT_TIME: t.wait_time = d;
      REG_LOW_TH_L:  t.low_th[7:0] = d;
      REG_LOW_TH_H:  t.low_th[15:8] = d;
      REG_HIGH_TH_L: t.high_th[7:0] = d;
      REG_HIGH_TH_H: t.high_th[15:8] = d;
      REG_PERSIST:   t.persist = d;
      REG_CONFIG:    t.config_r = d;
      REG_PULSES:    t.pulses = d;
      REG_CONTROL:   t.control = d;
      default:       t = s;
    endcase
    return t;
  endfunction

  // next state of the whole block
  always_comb
  begin
    logic       rise;
    logic       fall;
    logic       start_c;
    logic       stop_c;
    logic [7:0] byte_in;
    logic [7:0] rdat;
    logic       clr;
    logic       set;
    logic       event_c;
    logic [3:0] pcnt_inc;
    logic       power_on_bit;
    logic       prox_enable;
    logic       wen;
    logic [31:0] dur_accum;
    logic [31:0] dur_adc;
    logic [31:0] dur_wait;
    rise     = 1'b0;
    fall     = 1'b0;
    start_c  = 1'b0;
    stop_c   = 1'b0;
    byte_in  = 8'h00;
    rdat     = 8'h00;
    clr      = 1'b0;
    set      = 1'b0;
    event_c  = 1'b0;
    pcnt_inc = 4'h0;
    power_on_bit       = 1'b0;
    prox_enable       = 1'b0;
    wen       = 1'b0;
    dur_accum = 32'h0;
    dur_adc   = 32'h0;
    dur_wait  = 32'h0;
    state_next = state_reg;

    // bus edges and conditions seen on the synchronised pins
    rise    = scl_s & ~state_reg.scl_d;
    fall    = ~scl_s & state_reg.scl_d;
    start_c = scl_s & state_reg.scl_d & state_reg.sda_d & ~sda_s;
    stop_c  = scl_s & state_reg.scl_d & ~state_reg.sda_d & sda_s;
    byte_in = {state_reg.shreg[6:0], sda_s};
    rdat    = reg_read(state_reg, state_reg.addr);
    state_next.scl_d = scl_s;
    state_next.sda_d = sda_s;

    if (start_c)
    begin
      // a repeated start keeps the held address for the read that follows
      state_next.bus      = BUS_ADDR;
      state_next.bitn     = 3'h0;
      state_next.sda_oe_n = 1'b1;
    end
    else if (stop_c)
    begin
      state_next.bus      = BUS_IDLE;
      state_next.sda_oe_n = 1'b1;
    end
    else
    begin
      case (state_reg.bus)
        BUS_IDLE:
        begin
          state_next.sda_oe_n = 1'b1;
        end
        BUS_ADDR:
        begin
          if (rise)
          begin
            state_next.shreg = byte_in;
            state_next.bitn  = state_reg.bitn + 3'h1;
            if (state_reg.bitn == 3'h7)
            begin
              // other addresses: stay off the bus until the next start
              if (byte_in[7:1] == SLAVE_ADDR)
              begin
                state_next.bus   = BUS_ADDR_ACK;
                state_next.rnw   = byte_in[0];
                state_next.first = 1'b1;
              end
              else
              begin
                state_next.bus = BUS_IDLE;
              end
            end
          end
        end
        BUS_ADDR_ACK, BUS_WR_ACK:
        begin
          // first falling edge pulls sda low, the second ends the ack bit
          if (fall && state_reg.sda_oe_n)
          begin
            state_next.sda_oe_n = 1'b0;
          end
          else if (fall)
          begin
            state_next.bitn = 3'h0;
            if (state_reg.bus == BUS_ADDR_ACK && state_reg.rnw)
            begin
              state_next.bus      = BUS_RD_BYTE;
              state_next.shreg    = rdat;
              state_next.sda_oe_n = rdat[7];
            end
            else
            begin
              state_next.bus      = BUS_WR_BYTE;
              state_next.sda_oe_n = 1'b1;
            end
          end
        end
        BUS_WR_BYTE:
        begin
          if (rise)
          begin
            state_next.shreg = byte_in;
            state_next.bitn  = state_reg.bitn + 3'h1;
            if (state_reg.bitn == 3'h7)
            begin
              state_next.bus   = BUS_WR_ACK;
              state_next.first = 1'b0;
              if (state_reg.first && byte_in[CMD_FLAG_BIT])
              begin
                if (byte_in[6:5] == CT_SPECIAL)
                begin
                  // special function acts once and leaves nothing behind
                  clr = (byte_in[4:0] == SF_PIRQ_CLR_A) ||
                        (byte_in[4:0] == SF_PIRQ_CLR_B);
                end
                else
                begin
                  state_next.ctype = byte_in[6:5];
                  state_next.addr  = byte_in[4:0];
                end
              end
              else
              begin
                // data byte at the held address, stepping on auto-increment
                state_next = reg_write(state_next, state_reg.addr, byte_in);
                if (state_reg.ctype == CT_AUTO_INC)
                begin
                  state_next.addr = state_reg.addr + 5'h01;
                end
              end
            end
          end
        end
        BUS_RD_BYTE:
        begin
          if (fall && state_reg.bitn == 3'h7)
          begin
            state_next.bus      = BUS_RD_ACK;
            state_next.sda_oe_n = 1'b1;
            if (state_reg.ctype == CT_AUTO_INC)
            begin
              state_next.addr = state_reg.addr + 5'h01;
            end
          end
          else if (fall)
          begin
            state_next.shreg    = {state_reg.shreg[6:0], 1'b0};
            state_next.sda_oe_n = state_reg.shreg[6];
            state_next.bitn     = state_reg.bitn + 3'h1;
          end
        end
        BUS_RD_ACK:
        begin
          // a nack ends the read; the master then stops
          if (rise)
          begin
            state_next.bus = sda_s ? BUS_IDLE : BUS_RD_NEXT;
          end
        end
        BUS_RD_NEXT:
        begin
          if (fall)
          begin
            state_next.bus      = BUS_RD_BYTE;
            state_next.shreg    = rdat;
            state_next.sda_oe_n = rdat[7];
            state_next.bitn     = 3'h0;
          end
        end
        default:
        begin
          state_next.bus      = BUS_IDLE;
          state_next.sda_oe_n = 1'b1;
        end
      endcase
    end

    // durations use the settings as they stand when the state is entered
    power_on_bit = state_next.enable[ENA_POWER_ON_BIT];
    prox_enable = state_next.enable[ENA_PROX_BIT];
    wen = state_next.enable[ENA_WAIT_BIT];
    dur_accum = 32'((state_reg.pulses == 8'h00 ? 1 : int'(state_reg.pulses)) * PULSE_CYCLES)
                - 32'h1;
    dur_adc   = 32'((STEPS_FULL - int'(state_reg.int_time)) * STEP_CYCLES)
                - 32'h1;
    dur_wait  = 32'((STEPS_FULL - int'(state_reg.wait_time)) * STEP_CYCLES
                * (state_reg.config_r[CFG_LONG_WAIT] ? LONG_WAIT_MULT : 1))
                - 32'h1;
    state_next.tmr = state_reg.tmr - 32'h1;

    // measurement loop
    case (state_reg.ms)
      MS_SLEEP:
      begin
        if (power_on_bit && prox_enable)
        begin
          state_next.ms  = MS_ACCUM;
          state_next.tmr = dur_accum;
        end
        else if (power_on_bit && wen)
        begin
          state_next.ms  = MS_WAIT;
          state_next.tmr = dur_wait;
        end
      end
      MS_ACCUM:
      begin
        // power-off does not cut a conversion short
        if (state_reg.tmr == 32'h0)
        begin
          state_next.ms  = MS_ADC;
          state_next.tmr = dur_adc;
        end
      end
      MS_ADC:
      begin
        if (state_reg.tmr == 32'h0)
        begin
          state_next.result = adc_value_i;
          state_next.valid  = 1'b1;
          event_c = (adc_value_i > state_reg.high_th) ||
                    (adc_value_i < state_reg.low_th);
          pcnt_inc = (state_reg.pcnt == 4'hf) ? 4'hf : state_reg.pcnt + 4'h1;
          state_next.pcnt = event_c ? pcnt_inc : 4'h0;
          set = event_c && (pcnt_inc >= state_reg.persist[PERS_PROX_LSB +: 4]) &&
                state_reg.enable[ENA_PIRQ_BIT];
          if (!power_on_bit)
          begin
            state_next.ms = MS_SLEEP;
          end
          else if (wen)
          begin
            state_next.ms  = MS_WAIT;
            state_next.tmr = dur_wait;
          end
          else if (prox_enable)
          begin
            state_next.ms  = MS_ACCUM;
            state_next.tmr = dur_accum;
          end
          else
          begin
            state_next.ms = MS_SLEEP;
          end
        end
      end
      MS_WAIT:
      begin
        // waiting is no conversion, so power-off ends it at once
        if (!power_on_bit || !wen)
        begin
          state_next.ms = MS_SLEEP;
        end
        else if (state_reg.tmr == 32'h0)
        begin
          state_next.ms  = prox_enable ? MS_ACCUM : MS_WAIT;
          state_next.tmr = prox_enable ? dur_accum : dur_wait;
        end
      end
      default:
      begin
        state_next.ms = MS_SLEEP;
      end
    endcase

    // a fresh event wins over a clear in the same cycle
    state_next.pirq     = set | (state_reg.pirq & ~clr);
    state_next.irq_n    = ~state_next.pirq;
    state_next.led_on   = (state_next.ms == MS_ACCUM);
    state_next.adc_busy = (state_next.ms == MS_ADC);
  end

  // single register for all state; ce_i low freezes everything
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_reg           <= '0;
      state_reg.int_time  <= INT_TIME_RST;
      state_reg.wait_time <= WAIT_TIME_RST;
      state_reg.sda_oe_n  <= 1'b1;
      state_reg.scl_d     <= 1'b1;
      state_reg.sda_d     <= 1'b1;
      state_reg.irq_n     <= 1'b1;
    end
    else if (ce_i)
    begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state register; sda is open drain, pulled low only
  assign sda_o               = 1'b0;
  assign sda_oe_n_o          = state_reg.sda_oe_n;
  assign irq_n_o             = state_reg.irq_n;
  assign led_on_o            = state_reg.led_on;
  assign adc_busy_o          = state_reg.adc_busy;
  assign led_pulse_count_o   = state_reg.pulses;
  assign led_drive_level_o   = state_reg.control[7:6];
  assign photodiode_select_o = state_reg.control[5:4];
  assign prox_gain_o         = state_reg.control[3:2];

endmodule

// ==== sim/pxs_core_asserts.sv ====
// assertion checker for the proximity sensor control core
`timescale 1ns/100ps
module pxs_core_asserts
  import pxs_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = 20
) (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  input wire logic        ce_i,
  // bus pins
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_n_o,
  // front end and interrupt
  input wire logic [15:0] adc_value_i,
  input wire logic        led_on_o,
  input wire logic        adc_busy_o,
  input wire logic [7:0]  led_pulse_count_o,
  input wire logic [1:0]  led_drive_level_o,
  input wire logic [1:0]  photodiode_select_o,
  input wire logic [1:0]  prox_gain_o,
  input wire logic        irq_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // run lengths of accumulate and conversion, time since conversion, and bus quiet time
  logic [31:0] acc_reg, adc_reg, since_reg, scl_reg;
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      acc_reg   <= 32'h0;
      adc_reg   <= 32'h0;
      since_reg <= 32'h0;
      scl_reg   <= 32'h0;
    end
    else
    begin
      acc_reg   <= led_on_o ? acc_reg + 32'h1 : 32'h0;
      adc_reg   <= adc_busy_o ? adc_reg + 32'h1 : 32'h0;
      since_reg <= adc_busy_o ? 32'h0 : since_reg + 32'h1;
      scl_reg   <= scl_i ? scl_reg + 32'h1 : 32'h0;
    end
  end
  property p_mutex; !(led_on_o && adc_busy_o); endproperty
  a_mutex: assert property (p_mutex) else $error("accumulate and conversion overlap");
  property p_order; $rose(adc_busy_o) |-> $past(led_on_o); endproperty
  a_order: assert property (p_order) else $error("conversion without accumulate");
  property p_acc; $fell(led_on_o) |-> acc_reg != 0 && acc_reg % PULSE_CYCLES == 0; endproperty
  a_acc: assert property (p_acc) else $error("accumulate length wrong");
  property p_adc; $fell(adc_busy_o) |-> adc_reg != 0 && adc_reg % STEP_CYCLES == 0; endproperty
  a_adc: assert property (p_adc) else $error("conversion length wrong");
  property p_irq_set; $fell(irq_n_o) |-> since_reg <= 3; endproperty
  a_irq_set: assert property (p_irq_set) else $error("interrupt not at conversion end");
  property p_irq_hold; $rose(irq_n_o) |-> scl_reg < 20; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped without command");
  property p_oe_low; $changed(sda_oe_n_o) |-> !scl_i; endproperty
  a_oe_low: assert property (p_oe_low) else $error("data line moved with clock high");
  property p_oe_rel; $fell(sda_oe_n_o) |-> ##[1:130] sda_oe_n_o; endproperty
  a_oe_rel: assert property (p_oe_rel) else $error("data line held too long");
  c_irq: cover property ($fell(irq_n_o));
  c_adc: cover property ($rose(adc_busy_o));
  c_ack: cover property ($fell(sda_oe_n_o));
endmodule

bind pxs_core pxs_core_asserts #(.STEP_CYCLES(STEP_CYCLES)) u_chk (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .adc_value_i(adc_value_i), .led_on_o(led_on_o),
  .adc_busy_o(adc_busy_o), .led_pulse_count_o(led_pulse_count_o),
  .led_drive_level_o(led_drive_level_o), .photodiode_select_o(photodiode_select_o),
  .prox_gain_o(prox_gain_o), .irq_n_o(irq_n_o));

// ==== sim/pxs_master.sv ====
// bus master model driving the serial pins of the sensor core
`timescale 1ns/100ps
module pxs_master
  import pxs_pkg::*;
(
  // serial pins, clock idles high between frames
  output logic      scl_o,
  output logic      sda_o,
  input  wire logic sda_i
);
  localparam real Q = 31.25;  // quarter of the 125 ns bit time
  logic nack = 1'b0;          // any refused byte in the last transfer
  initial scl_o = 1'b1;
  initial sda_o = 1'b1;
  // one bit: data moves only while the clock is low
  task automatic bit_x(input logic b, output logic r);
    #Q sda_o = b;
    #Q scl_o = 1'b1;
    #Q r = sda_i;
    #Q scl_o = 1'b0;
  endtask
  // start and repeated start share one shape
  task automatic start();
    #Q sda_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b0;
    #Q scl_o = 1'b0;
  endtask
  task automatic stop();
    #Q sda_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b1;
    #Q;
  endtask
  task automatic put(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    nack = nack | r;
  endtask
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask
  // write: command byte with top bit first, then data, lowest byte of v first
  task automatic wr(input logic [6:0] a, input logic [47:0] v, input int n);
    nack = 1'b0;
    start();
    put({a, 1'b0});
    for (int i = 0; i < n; i++) put(v[8*i +: 8]);
    stop();
  endtask
  // read n bytes, low first; command 0 skips the command phase
  task automatic rd(input logic [7:0] c, input int n, output logic [31:0] d);
    nack = 1'b0;
    d = 32'h0;
    if (c[CMD_FLAG_BIT])
    begin
      start();
      put({SLAVE_ADDR, 1'b0});
      put(c);
    end
    start();
    put({SLAVE_ADDR, 1'b1});
    for (int i = 0; i < n; i++) get(i == n - 1, d[8*i +: 8]);
    stop();
  endtask
endmodule

// ==== sim/pxs_core_tb.sv ====
// self-checking bench for the proximity sensor control core
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module pxs_core_tb;
  import pxs_pkg::*;
  localparam int unsigned STEP = 20;  // short step keeps the run brief
  logic        clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        ce_i = 1'b1;
  logic [15:0] adc_value_i = 16'h0;
  logic        sda_o, sda_oe_n_o, led_on_o, adc_busy_o, irq_n_o;
  logic [7:0]  led_pulse_count_o;
  logic [1:0]  led_drive_level_o, photodiode_select_o, prox_gain_o;
  wire         scl, sda_m, sda;
  int          error_cnt = 0, comparisons = 0, cyc = 0, n, gs, gl;
  logic [31:0] d;
  // open drain line with pull-up
  assign sda = sda_m & (sda_oe_n_o | sda_o);
  pxs_master m (.scl_o(scl), .sda_o(sda_m), .sda_i(sda));
  pxs_core #(.STEP_CYCLES(STEP)) uut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .adc_value_i(adc_value_i), .led_on_o(led_on_o),
    .adc_busy_o(adc_busy_o), .led_pulse_count_o(led_pulse_count_o),
    .led_drive_level_o(led_drive_level_o), .photodiode_select_o(photodiode_select_o),
    .prox_gain_o(prox_gain_o), .irq_n_o(irq_n_o));
  always #5 clk_i = ~clk_i;
  // hang guard
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      error_cnt++;
      summarize();
    end
  end
  task automatic summarize();
    $display("error_cnt=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wreg(input logic [4:0] r, input logic [7:0] v);
    m.wr(SLAVE_ADDR, {v, 3'h4, r}, 2);
  endtask
  task automatic chk_reg(input logic [4:0] r, input logic [7:0] e);
    m.rd({3'h4, r}, 1, d);
    `CHK(d[7:0], e)
  endtask
  // bounded wait for a level, counted in cycles
  task automatic till(ref logic s, input logic v, output int k);
    k = 0;
    while (s !== v && k < 20000)
    begin
      @(posedge clk_i);
      #1;
      k++;
    end
    `CHK(s, v)
  endtask
  task automatic conv();
    till(adc_busy_o, 1'b1, n);
    till(adc_busy_o, 1'b0, n);
    repeat (5) @(posedge clk_i);
    #1;
  endtask
  task automatic set_adc(input logic [15:0] v);
    @(posedge clk_i);
    #1 adc_value_i = v;
  endtask
  initial
  begin
    repeat (4) @(posedge clk_i);
    #1 arst_n_i = 1'b1;
    repeat (10) @(posedge clk_i);
    `CHK({irq_n_o, led_on_o, adc_busy_o, led_pulse_count_o}, 11'h400)
    chk_reg(REG_INT_TIME, 8'hff);
    chk_reg(REG_WAIT_TIME, 8'hff);
    m.wr(7'h3a, 48'h058e, 2);
    `CHK({m.nack, led_pulse_count_o}, 9'h100)
    wreg(REG_PULSES, 8'h05);
    `CHK({m.nack, led_pulse_count_o}, 9'h005)
    wreg(REG_CONTROL, 8'he4);
    `CHK({led_drive_level_o, photodiode_select_o, prox_gain_o}, 6'h39)
    m.wr(SLAVE_ADDR, 48'h24, 1);
    `CHK({led_drive_level_o, photodiode_select_o, prox_gain_o}, 6'h09)
    m.rd(8'h00, 1, d);
    `CHK(d[7:0], 8'h24)
    wreg(REG_PULSES, 8'h01);
    m.wr(SLAVE_ADDR, {16'h0800, 16'h0100, 8'ha8}, 5);
    m.rd(8'ha8, 4, d);
    `CHK(d, 32'h0800_0100)
    m.rd(8'h89, 2, d);
    `CHK(d[15:0], 16'h0101)
    m.rd(8'hc9, 2, d);
    `CHK(d[15:0], 16'h0101)
    wreg(REG_PERSIST, 8'h20);
    set_adc(16'h0900);
    wreg(REG_ENABLE, 8'h25);
    till(led_on_o, 1'b1, n);
    conv();
    `CHK(irq_n_o, 1'b1)
    conv();
    `CHK(irq_n_o, 1'b0)
    m.rd(8'hb8, 2, d);
    `CHK(d[15:0], 16'h0900)
    chk_reg(REG_STATUS, 8'h21);
    set_adc(16'h0400);
    conv();
    `CHK(irq_n_o, 1'b0)
    m.wr(SLAVE_ADDR, 48'he7, 1);
    repeat (20) @(posedge clk_i);
    `CHK(irq_n_o, 1'b1)
    conv();
    `CHK(irq_n_o, 1'b1)
    wreg(REG_PERSIST, 8'h00);
    set_adc(16'h0050);
    conv();
    `CHK(irq_n_o, 1'b0)
    set_adc(16'h0400);
    m.wr(SLAVE_ADDR, 48'he5, 1);
    repeat (20) @(posedge clk_i);
    `CHK(irq_n_o, 1'b1)
    wreg(REG_ENABLE, 8'h05);
    set_adc(16'h0900);
    conv();
    conv();
    `CHK(irq_n_o, 1'b1)
    // wait gap between conversion end and next accumulate
    wreg(REG_ENABLE, 8'h0d);
    conv();
    till(led_on_o, 1'b1, gs);
    `CHK(gs >= STEP - 5 && gs <= STEP, 1'b1)
    wreg(REG_CONFIG, 8'h02);
    conv();
    till(led_on_o, 1'b1, gl);
    `CHK(gl - gs, 11 * STEP)
    // power off in mid accumulate
    till(led_on_o, 1'b1, n);
    wreg(REG_ENABLE, 8'h04);
    conv();
    repeat (3000) @(posedge clk_i);
    `CHK({led_on_o, adc_busy_o}, 2'b00)
    summarize();
  end
endmodule
